// [core/e3tx_map.svh]
// Register offsets, field positions, reset values and frame constants
// for the transmit E3 frame assembler.
// Assumes inclusion by bare name from core/ files.
`ifndef E3TX_MAP_SVH
`define E3TX_MAP_SVH

// Register indices; byte address is four times the index
`define E3TX_IDX_ALARM_CFG 8'h30
`define E3TX_IDX_MA_BYTE 8'h36
`define E3TX_IDX_STATUS 8'h40
`define E3TX_ADDR_W 12

// Alarm configuration fields
`define E3TX_CFG_AUTO_RI 0
`define E3TX_CFG_LOS 1
`define E3TX_CFG_AIS 2
`define E3TX_CFG_DL_NR 4
`define E3TX_CFG_WMASK 8'h17
`define E3TX_CFG_RESET 8'h00

// Maintenance byte fields
`define E3TX_MA_REMOTE_FAILURE_FLAG 7
`define E3TX_MA_REMOTE_BLOCK_ERROR_FLAG 6
`define E3TX_MA_RESET 8'h10

// Status fields
`define E3TX_ST_UNDERRUN 0
`define E3TX_ST_MODE_LO 1
`define E3TX_ST_MODE_HI 2

// Frame layout and fixed bytes
`define E3TX_ROWS 9
`define E3TX_ROW_LEN 60
`define E3TX_FA1 8'hF6
`define E3TX_FA2 8'h28
`define E3TX_OH_IDLE 8'h00
`define E3TX_AIS_BYTE 8'hFF
`define E3TX_LOS_BYTE 8'h00

// AXI responses
`define E3TX_RESP_OKAY 2'b00
`define E3TX_RESP_SLVERR 2'b10

`endif

// [core/e3tx_pkg.sv]
// Types shared by the transmit E3 frame assembler.
// Assumes nothing of its surroundings.
package e3tx_pkg;

  // Kind of byte slot in the outbound frame
  typedef enum logic [2:0] {
    E3TX_SLOT_FA1,
    E3TX_SLOT_FA2,
    E3TX_SLOT_EM,
    E3TX_SLOT_TR,
    E3TX_SLOT_MA,
    E3TX_SLOT_NR,
    E3TX_SLOT_GC,
    E3TX_SLOT_PAYLOAD
  } e3tx_slot_e;

  // Outbound traffic mode
  typedef enum logic [1:0] {
    E3TX_MODE_NORMAL,
    E3TX_MODE_AIS,
    E3TX_MODE_LOS
  } e3tx_mode_e;

endpackage

// [core/e3tx_bip8.sv]
// Bit-interleaved parity over one frame of bytes.
// Assumes frame_start marks the first byte of each frame on aclk.
`timescale 1ns/1ps
module e3tx_bip8 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Byte stream
  input wire logic byte_en,
  input wire logic frame_start,
  input wire logic [WIDTH-1:0] byte_in,
  // Parity of the previous frame
  output logic [WIDTH-1:0] parity
);

  logic [WIDTH-1:0] acc;
  logic [WIDTH-1:0] next_acc;
  logic [WIDTH-1:0] next_parity;

  always_comb begin
    next_acc = acc;
    next_parity = parity;
    if (byte_en && frame_start) begin
      next_parity = acc;
      next_acc = byte_in;
    end else if (byte_en) begin
      next_acc = acc ^ byte_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      parity <= '0;
    end else begin
      acc <= next_acc;
      parity <= next_parity;
    end
  end

endmodule

// [core/e3tx_frame_mux.sv]
// Transmit E3 frame assembler: merges payload, overhead, data-link and
// internal bytes into outbound frames, one byte per clock.
// Assumes payload, overhead, HDLC and receiver inputs share aclk.
`timescale 1ns/1ps
`include "e3tx_map.svh"
module e3tx_frame_mux
  import e3tx_pkg::*;
#(
  parameter int ROWS = `E3TX_ROWS,
  parameter int ROW_LEN = `E3TX_ROW_LEN
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`E3TX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`E3TX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Payload input
  input wire logic [7:0] pl_data,
  input wire logic pl_valid,
  output logic pl_ready,
  // Overhead input
  input wire logic oh_active,
  input wire logic [7:0] oh_data,
  input wire logic oh_valid,
  output logic oh_ready,
  output logic [2:0] oh_slot,
  // HDLC controller
  input wire logic hdlc_enable,
  input wire logic [7:0] hdlc_data,
  input wire logic hdlc_valid,
  output logic hdlc_ready,
  // Receiver status of the same channel
  input wire logic rx_los,
  input wire logic rx_ais,
  input wire logic rx_lof,
  input wire logic rx_bip_err,
  // Line port
  output logic [7:0] line_data,
  output logic line_valid,
  output logic line_frame_start
);

  if (ROWS < 7 || ROWS > 255) begin : g_rows_chk
    $error("ROWS must lie between 7 and 255");
  end
  if (ROW_LEN < 2 || ROW_LEN > 255) begin : g_len_chk
    $error("ROW_LEN must lie between 2 and 255");
  end

  localparam logic [7:0] LAST_ROW = 8'(ROWS - 1);
  localparam logic [7:0] LAST_COL = 8'(ROW_LEN - 1);

  // Slot of a byte position: column 0 of rows 0..6 holds overhead
  function automatic e3tx_slot_e slot_of(input logic [7:0] r,
                                         input logic [7:0] c);
    e3tx_slot_e s;
    s = E3TX_SLOT_PAYLOAD;
    if (c == 8'h00 && r < 8'h07) begin
      s = e3tx_slot_e'(r[2:0]);
    end
    return s;
  endfunction

  // Register state
  logic [7:0] alarm_cfg;
  logic [7:0] ma_reg;
  logic underrun;
  logic [7:0] next_alarm_cfg;
  logic [7:0] next_ma_reg;
  logic next_underrun;

  // Bus state
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;

  // Frame state
  logic [7:0] row;
  logic [7:0] col;
  logic [7:0] next_row;
  logic [7:0] next_col;
  logic bip_seen;
  logic next_bip_seen;
  logic next_pl_ready;
  logic next_oh_ready;
  logic [2:0] next_oh_slot;
  logic next_hdlc_ready;
  logic [7:0] next_line_data;
  logic next_line_frame_start;
  e3tx_slot_e slot;
  e3tx_slot_e next_slot;
  e3tx_mode_e mode;
  logic [7:0] frame_byte;
  logic [7:0] em_parity;
  logic next_dl_slot;
  logic remote_failure_flag;
  logic remote_block_error_flag;

  // Register bus
  logic wr_go;
  logic rd_go;
  logic [`E3TX_ADDR_W-1:0] ma_addr;
  logic [`E3TX_ADDR_W-1:0] cfg_addr;
  logic [`E3TX_ADDR_W-1:0] st_addr;
  logic [7:0] status;

  assign cfg_addr = `E3TX_ADDR_W'({`E3TX_IDX_ALARM_CFG, 2'b00});
  assign ma_addr = `E3TX_ADDR_W'({`E3TX_IDX_MA_BYTE, 2'b00});
  assign st_addr = `E3TX_ADDR_W'({`E3TX_IDX_STATUS, 2'b00});
  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = s_axi_arready && s_axi_arvalid;

  // Traffic mode, signal loss first
  always_comb begin
    if (alarm_cfg[`E3TX_CFG_LOS]) begin
      mode = E3TX_MODE_LOS;
    end else if (alarm_cfg[`E3TX_CFG_AIS]) begin
      mode = E3TX_MODE_AIS;
    end else begin
      mode = E3TX_MODE_NORMAL;
    end
  end

  always_comb begin
    status = 8'h00;
    status[`E3TX_ST_UNDERRUN] = underrun;
    status[`E3TX_ST_MODE_HI:`E3TX_ST_MODE_LO] = mode;
  end

  always_comb begin
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_alarm_cfg = alarm_cfg;
    next_ma_reg = ma_reg;
    // Both channels taken together once both are offered
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = `E3TX_RESP_OKAY;
      if (s_axi_awaddr == cfg_addr) begin
        if (s_axi_wstrb[0]) begin
          next_alarm_cfg = s_axi_wdata[7:0] & `E3TX_CFG_WMASK;
        end
      end else if (s_axi_awaddr == ma_addr) begin
        if (s_axi_wstrb[0]) begin
          next_ma_reg = s_axi_wdata[7:0];
        end
      end else if (s_axi_awaddr != st_addr) begin
        next_bresp = `E3TX_RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = `E3TX_RESP_OKAY;
      if (s_axi_araddr == cfg_addr) begin
        next_rdata = {24'h000000, alarm_cfg};
      end else if (s_axi_araddr == ma_addr) begin
        next_rdata = {24'h000000, ma_reg};
      end else if (s_axi_araddr == st_addr) begin
        next_rdata = {24'h000000, status};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = `E3TX_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `E3TX_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `E3TX_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      alarm_cfg <= `E3TX_CFG_RESET;
      ma_reg <= `E3TX_MA_RESET;
    end else begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      alarm_cfg <= next_alarm_cfg;
      ma_reg <= next_ma_reg;
    end
  end

  // Frame position
  assign slot = slot_of(row, col);

  always_comb begin
    next_row = row;
    next_col = col + 8'h01;
    if (col == LAST_COL) begin
      next_col = 8'h00;
      next_row = (row == LAST_ROW) ? 8'h00 : row + 8'h01;
    end
  end

  assign next_slot = slot_of(next_row, next_col);
  assign next_dl_slot = alarm_cfg[`E3TX_CFG_DL_NR] ?
    (next_slot == E3TX_SLOT_NR) : (next_slot == E3TX_SLOT_GC);

  // Remote indicators
  assign remote_failure_flag = alarm_cfg[`E3TX_CFG_AUTO_RI] ?
    (rx_los || rx_ais || rx_lof) : ma_reg[`E3TX_MA_REMOTE_FAILURE_FLAG];
  assign remote_block_error_flag = alarm_cfg[`E3TX_CFG_AUTO_RI] ?
    bip_seen : ma_reg[`E3TX_MA_REMOTE_BLOCK_ERROR_FLAG];

  e3tx_bip8 #(
    .WIDTH(8)
  ) u_bip8 (
    .aclk(aclk),
    .aresetn(aresetn),
    .byte_en(1'b1),
    .frame_start(row == 8'h00 && col == 8'h00),
    .byte_in(frame_byte),
    .parity(em_parity)
  );

  // Byte selection for the current slot
  always_comb begin
    frame_byte = `E3TX_OH_IDLE;
    case (slot)
      E3TX_SLOT_FA1: frame_byte = `E3TX_FA1;
      E3TX_SLOT_FA2: frame_byte = `E3TX_FA2;
      E3TX_SLOT_EM: frame_byte = em_parity;
      E3TX_SLOT_MA: begin
        frame_byte = {remote_failure_flag, remote_block_error_flag, ma_reg[5:0]};
        if (oh_ready && oh_valid && oh_active) begin
          frame_byte = {remote_failure_flag, remote_block_error_flag, oh_data[5:0]};
        end
      end
      E3TX_SLOT_TR, E3TX_SLOT_NR, E3TX_SLOT_GC: begin
        if (hdlc_ready && hdlc_valid) begin
          frame_byte = hdlc_data;
        end else if (oh_ready && oh_valid && oh_active) begin
          frame_byte = oh_data;
        end
      end
      E3TX_SLOT_PAYLOAD: begin
        frame_byte = (pl_ready && pl_valid) ? pl_data : 8'h00;
      end
      default: frame_byte = `E3TX_OH_IDLE;
    endcase
  end

  always_comb begin
    next_bip_seen = bip_seen;
    if (slot == E3TX_SLOT_MA) begin
      next_bip_seen = 1'b0;
    end
    if (rx_bip_err) begin
      next_bip_seen = 1'b1;
    end
    next_underrun = underrun;
    if (wr_go && s_axi_awaddr == st_addr && s_axi_wstrb[0] &&
        s_axi_wdata[`E3TX_ST_UNDERRUN]) begin
      next_underrun = 1'b0;
    end
    if (pl_ready && !pl_valid) begin
      next_underrun = 1'b1;
    end
    next_pl_ready = (next_slot == E3TX_SLOT_PAYLOAD);
    next_oh_ready = oh_active &&
      (next_slot == E3TX_SLOT_MA || next_slot == E3TX_SLOT_TR ||
       next_slot == E3TX_SLOT_NR || next_slot == E3TX_SLOT_GC);
    next_oh_slot = next_slot;
    next_hdlc_ready = hdlc_enable && next_dl_slot;
    if (next_hdlc_ready) begin
      next_oh_ready = 1'b0;
    end
    case (mode)
      E3TX_MODE_LOS: next_line_data = `E3TX_LOS_BYTE;
      E3TX_MODE_AIS: next_line_data = `E3TX_AIS_BYTE;
      E3TX_MODE_NORMAL: next_line_data = frame_byte;
      default: next_line_data = frame_byte;
    endcase
    next_line_frame_start = (row == 8'h00 && col == 8'h00);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row <= 8'h00;
      col <= 8'h00;
      bip_seen <= 1'b0;
      underrun <= 1'b0;
      pl_ready <= 1'b0;
      oh_ready <= 1'b0;
      oh_slot <= 3'h0;
      hdlc_ready <= 1'b0;
      line_data <= 8'h00;
      line_valid <= 1'b0;
      line_frame_start <= 1'b0;
    end else begin
      row <= next_row;
      col <= next_col;
      bip_seen <= next_bip_seen;
      underrun <= next_underrun;
      pl_ready <= next_pl_ready;
      oh_ready <= next_oh_ready;
      oh_slot <= next_oh_slot;
      hdlc_ready <= next_hdlc_ready;
      line_data <= next_line_data;
      line_valid <= 1'b1;
      line_frame_start <= next_line_frame_start;
    end
  end

endmodule

// [bench/e3tx_props.sv]
// Checker for the transmit E3 frame assembler, bound to its ports.
// Assumes aclk and synchronous active-low aresetn on every port.
`timescale 1ns/1ps
`include "e3tx_map.svh"
module e3tx_props
  import e3tx_pkg::*;
(
  // Clock, reset and write bus
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [`E3TX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Sources and receiver status
  input wire logic [7:0] pl_data, oh_data, hdlc_data,
  input wire logic pl_valid, pl_ready, oh_valid, oh_ready, hdlc_enable,
  input wire logic hdlc_valid, hdlc_ready, rx_los, rx_ais, rx_lof,
  input wire logic [2:0] oh_slot,
  // Line port
  input wire logic [7:0] line_data,
  input wire logic line_valid, line_frame_start
);
  logic [7:0] cfg;
  logic norm, fault;
  // Shadow of the alarm configuration
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cfg <= `E3TX_CFG_RESET;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == 12'h0C0 && s_axi_wstrb[0])
      cfg <= s_axi_wdata[7:0] & `E3TX_CFG_WMASK;
  end
  assign norm = cfg[2:1] == 2'b00;
  assign fault = rx_los || rx_ais || rx_lof;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp; s_wr_taken |=> s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_fa1; oh_slot == E3TX_SLOT_FA1 && norm
    |=> line_frame_start && line_data == `E3TX_FA1; endproperty
  a_fa1: assert property (p_fa1)
    else $error("first alignment byte wrong");
  property p_fa2; oh_slot == E3TX_SLOT_FA2 && norm
    |=> line_data == `E3TX_FA2; endproperty
  a_fa2: assert property (p_fa2)
    else $error("second alignment byte wrong");
  property p_ais; cfg[2] && !cfg[1] |=> line_data == `E3TX_AIS_BYTE;
  endproperty
  a_ais: assert property (p_ais)
    else $error("alarm pattern wrong");
  property p_los; cfg[1] |=> line_data == `E3TX_LOS_BYTE; endproperty
  a_los: assert property (p_los)
    else $error("loss pattern wrong");
  property p_no_oh; oh_slot <= 3'h2 |-> !oh_ready; endproperty
  a_no_oh: assert property (p_no_oh)
    else $error("overhead taken for fixed byte");
  property p_pl; pl_ready && pl_valid && norm
    |=> line_data == $past(pl_data); endproperty
  a_pl: assert property (p_pl)
    else $error("payload byte lost");
  property p_oh; oh_ready && oh_valid && norm && oh_slot inside {3'h3, 3'h5,
    3'h6} |=> line_data == $past(oh_data); endproperty
  a_oh: assert property (p_oh)
    else $error("overhead byte lost");
  property p_hdlc; hdlc_ready && hdlc_valid && hdlc_enable && norm
    |=> line_data == $past(hdlc_data); endproperty
  a_hdlc: assert property (p_hdlc)
    else $error("data link byte lost");
  property p_remote_failure_flag; oh_slot == E3TX_SLOT_MA && cfg[0] && norm
    && fault == $past(fault) |=> line_data[7] == $past(fault); endproperty
  a_remote_failure_flag: assert property (p_remote_failure_flag)
    else $error("failure flag wrong");
  property p_line; $past(aresetn) |-> line_valid; endproperty
  a_line: assert property (p_line)
    else $error("line stream stopped");
endmodule
bind e3tx_frame_mux e3tx_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb, .pl_data,
  .oh_data, .hdlc_data, .pl_valid, .pl_ready, .oh_valid, .oh_ready,
  .hdlc_enable, .hdlc_valid, .hdlc_ready, .rx_los, .rx_ais, .rx_lof,
  .oh_slot, .line_data, .line_valid, .line_frame_start);

// [bench/e3tx_src.sv]
// Terminal equipment model: payload and overhead byte sources.
// Assumes the framer's ready strobes on aclk; stall comes from the bench.
`timescale 1ns/1ps
module e3tx_src (
  // Clock, reset and control
  input wire logic aclk, aresetn, stall, oh_active,
  // Strobes from the framer
  input wire logic pl_ready, oh_ready,
  // Source data
  output logic [7:0] pl_data, oh_data,
  output logic pl_valid, oh_valid
);
  logic [7:0] cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cnt <= 8'h00;
    else if ((pl_ready && pl_valid) || (oh_ready && oh_valid))
      cnt <= cnt + 8'h01;
  end
  // Idle lines show the inverse, never the next byte
  assign pl_valid = !stall;
  assign oh_valid = oh_active && !stall;
  assign pl_data = pl_valid ? cnt : ~cnt;
  assign oh_data = oh_valid ? cnt ^ 8'h5A : ~cnt;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the transmit E3 frame assembler.
// Assumes the checker is bound to the design and e3tx_src feeds it.
`timescale 1ns/1ps
`include "e3tx_map.svh"
module testbench;
  import e3tx_pkg::*;
  localparam int RL = 12;
  localparam int FR = 9 * RL;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode, ma_fl, ma_exp;
  logic bip_m, remote_block_error_flag_q;
  logic [7:0] pl_data, oh_data, hdlc_data, line_data, par, par_prev;
  logic pl_valid, pl_ready, oh_active, oh_valid, oh_ready, hdlc_enable;
  logic hdlc_valid, hdlc_ready, rx_los, rx_ais, rx_lof, rx_bip_err, stall;
  logic line_valid, line_frame_start, mon, started, have, auto_m;
  logic [2:0] oh_slot, slot_q;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int nfs;
  e3tx_frame_mux #(.ROWS(9), .ROW_LEN(RL)) u_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pl_data,
    .pl_valid, .pl_ready, .oh_active, .oh_data, .oh_valid, .oh_ready,
    .oh_slot, .hdlc_enable, .hdlc_data, .hdlc_valid, .hdlc_ready, .rx_los,
    .rx_ais, .rx_lof, .rx_bip_err, .line_data, .line_valid,
    .line_frame_start);
  e3tx_src u_src (.aclk, .aresetn, .stall, .oh_active, .pl_ready,
    .oh_ready, .pl_data, .oh_data, .pl_valid, .oh_valid);
  task end_of_test();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d,
              input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task axi_rd(input logic [11:0] a, input logic [31:0] e,
              input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task run(input logic [1:0] m, input int nfr);
    mode = m;
    repeat (FR) @(posedge aclk);
    started = 0;
    have = 0;
    nfs = 0;
    mon = 1;
    repeat (nfr * FR) @(posedge aclk);
    mon = 0;
    if (m == 2'd0) chk("frames", nfr, nfs);
  endtask
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    stall = 0;
    hdlc_valid = 0;
    hdlc_data = 0;
    rx_bip_err = 0;
    forever begin
      @(posedge aclk);
      stall <= ($urandom % 4) == 0;
      hdlc_valid <= $urandom % 2;
      hdlc_data <= $urandom;
      rx_bip_err <= ($urandom % 16) == 0;
    end
  end
  always @(posedge aclk) slot_q <= oh_slot;
  // Expected block error flag: receiver errors since the last MA slot
  always @(posedge aclk) begin
    if (!aresetn) begin
      bip_m <= 1'b0;
    end else begin
      if (oh_slot == E3TX_SLOT_MA) remote_block_error_flag_q <= bip_m;
      bip_m <= (bip_m && oh_slot != E3TX_SLOT_MA) || rx_bip_err;
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Line monitor, one byte per cycle, settled at the falling edge
  always @(negedge aclk) begin
    if (mon) begin
      if (line_frame_start === 1'b1) nfs++;
      if (mode == 2'd1) chk("ais", `E3TX_AIS_BYTE, line_data);
      else if (mode == 2'd2) chk("los", `E3TX_LOS_BYTE, line_data);
      else begin
        if (slot_q == E3TX_SLOT_FA1) begin
          par_prev = par;
          have = started;
          started = 1;
          par = 8'h00;
        end
        par = par ^ line_data;
        if (slot_q == E3TX_SLOT_EM && have) chk("em", par_prev, line_data);
        if (!oh_active && slot_q inside {3'h3, 3'h5, 3'h6})
          chk("idle_oh", `E3TX_OH_IDLE, line_data);
        ma_exp = auto_m ? {rx_ais, remote_block_error_flag_q} : ma_fl;
        if (slot_q == E3TX_SLOT_MA)
          chk("ma_flags", ma_exp, line_data[7:6]);
      end
    end
  end
  initial begin : main
    logic [31:0] v;
    v = $urandom(55);
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, oh_active, hdlc_enable} = 4'h0;
    {rx_los, rx_ais, rx_lof, mon, auto_m} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {mode, ma_fl, par, par_prev} = 20'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(12'h0C0, 32'h00, `E3TX_RESP_OKAY);
    axi_rd(12'h3FC, 32'h00, `E3TX_RESP_SLVERR);
    axi_wr(12'h3FC, 32'hFF, `E3TX_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : $urandom;
      axi_wr(12'h0C0, v, `E3TX_RESP_OKAY);
      axi_rd(12'h0C0, v & 32'h17, `E3TX_RESP_OKAY);
    end
    axi_wr(12'h0C0, 32'h00, `E3TX_RESP_OKAY);
    axi_wr(12'h0D8, 32'hC0, `E3TX_RESP_OKAY);
    ma_fl = 2'b11;
    run(2'd0, 3);
    axi_wr(12'h0C0, 32'h01, `E3TX_RESP_OKAY);
    auto_m = 1;
    rx_ais <= 1'b1;
    run(2'd0, 2);
    auto_m = 0;
    rx_ais <= 1'b0;
    axi_wr(12'h0C0, 32'h00, `E3TX_RESP_OKAY);
    oh_active <= 1'b1;
    hdlc_enable <= 1'b1;
    run(2'd0, 3);
    axi_wr(12'h0C0, 32'h10, `E3TX_RESP_OKAY);
    run(2'd0, 2);
    axi_wr(12'h0C0, 32'h04, `E3TX_RESP_OKAY);
    run(2'd1, 2);
    axi_wr(12'h0C0, 32'h06, `E3TX_RESP_OKAY);
    run(2'd2, 2);
    axi_wr(12'h0C0, 32'h00, `E3TX_RESP_OKAY);
    run(2'd0, 1);
    end_of_test();
  end
endmodule
